// ### ism_host.sv
// host sequencer driving the two-wire bus master peripheral by its registers
// assumes the peripheral answers a read one cycle after rd, same clock
// Function
// - read status one, then write address byte to data register
// - after address event read status one, then write bus_control
// - ninth clock carries acknowledge from receiver to transmitter
// - receive: read status one, then read data register per byte
// - set stop request before reading the final received byte
// - clear acknowledge enable just before reading second-last byte
// - transmit: read status one, then write next byte
// - set stop request after writing the final transmitted byte
// - missing acknowledge: failure flag, resume with start or stop (this host always writes stop)
// - enable by writing bus_control twice with peripheral enable set
//
// Register access over APB and the register offsets were chosen for this implementation.
`timescale 1ns/1ps

module ism_host (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output ism_pkg::ism_dev_s dev_req,
  input wire logic [7:0] dev_rdata
);

  ism_pkg::ism_regs_s s_reg;
  ism_pkg::ism_regs_s s_next;

  // states that read a peripheral register, and which one
  function automatic logic is_read_state(input ism_pkg::ism_state_e st);
    case (st)
      ism_pkg::ST_POLL_SB, ism_pkg::ST_POLL_EV2, ism_pkg::ST_CHK_AF,
      ism_pkg::ST_RE_SR1, ism_pkg::ST_TX_POLL, ism_pkg::ST_RX_POLL,
      ism_pkg::ST_RX_RD, ism_pkg::ST_POLL_IDLE: is_read_state = 1'b1;
      default: is_read_state = 1'b0;
    endcase
  endfunction

  function automatic logic [7:0] read_addr(input ism_pkg::ism_state_e st);
    case (st)
      ism_pkg::ST_CHK_AF: read_addr = ism_pkg::DEV_STATUS_TWO;
      ism_pkg::ST_RX_RD: read_addr = ism_pkg::DEV_DATA;
      default: read_addr = ism_pkg::DEV_STATUS_ONE;
    endcase
  endfunction

  // one-cycle write request toward the peripheral
  function automatic ism_pkg::ism_dev_s dev_write(input logic [7:0] a,
                                                  input logic [7:0] d);
    dev_write.addr = a;
    dev_write.wdata = d;
    dev_write.wr = 1'b1;
    dev_write.rd = 1'b0;
  endfunction

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ism_pkg::OFS_CONTROL) || (a == ism_pkg::OFS_SLAVE) ||
                (a == ism_pkg::OFS_TX) || (a == ism_pkg::OFS_RX) ||
                (a == ism_pkg::OFS_STATUS);
  endfunction

  logic [7:0] cr_pe;
  logic [7:0] cr_ack;
  logic [7:0] cr_stop;
  logic [7:0] cr_start;
  logic [7:0] word_addr;
  logic apb_setup;
  logic apb_done;
  logic ev;
  logic [31:0] status_word;

  assign cr_pe = 8'h01 << ism_pkg::CR_PERIPHERAL_ENABLE;
  assign cr_ack = 8'h01 << ism_pkg::CR_ACK_ENABLE;
  assign cr_stop = 8'h01 << ism_pkg::CR_STOP_REQUEST;
  assign cr_start = 8'h01 << ism_pkg::CR_START_REQUEST;
  assign word_addr = {paddr[7:2], 2'h0};
  assign apb_setup = psel && !penable;
  assign apb_done = psel && penable && s_reg.pready;
  assign ev = dev_rdata[ism_pkg::SR1_EVENT];

  always_comb
  begin
    status_word = 32'h0000_0000;
    status_word[ism_pkg::STA_BUSY] = s_reg.busy;
    status_word[ism_pkg::STA_DONE] = s_reg.done;
    status_word[ism_pkg::STA_NACK] = s_reg.nack;
    status_word[ism_pkg::STA_TX_FULL] = s_reg.tx_full;
    status_word[ism_pkg::STA_RX_VALID] = s_reg.rx_valid;
  end

  always_comb
  begin
    s_next = s_reg;
    s_next.dev.wr = 1'b0;
    s_next.dev.rd = 1'b0;

    // register slave: answer at the cycle after setup
    s_next.pready = apb_setup;
    if (apb_setup)
    begin
      s_next.pslverr = !is_mapped(word_addr);
      s_next.prdata = 32'h0000_0000;
      case (word_addr)
        ism_pkg::OFS_CONTROL:
          s_next.prdata = {8'h00, s_reg.len, 1'b0, s_reg.div, 5'h00,
                           s_reg.fast, s_reg.rx_dir, 1'b0};
        ism_pkg::OFS_SLAVE: s_next.prdata = {25'h0000000, s_reg.saddr};
        ism_pkg::OFS_TX: s_next.prdata = {24'h000000, s_reg.tx_data};
        ism_pkg::OFS_RX: s_next.prdata = {24'h000000, s_reg.rx_data};
        ism_pkg::OFS_STATUS: s_next.prdata = status_word;
        default: s_next.prdata = 32'h0000_0000;
      endcase
    end
    if (apb_done && pwrite)
    begin
      case (word_addr)
        ism_pkg::OFS_CONTROL:
          if (!s_reg.busy)
          begin
            s_next.rx_dir = pwdata[ism_pkg::CTL_READ];
            s_next.fast = pwdata[ism_pkg::CTL_FAST];
            s_next.div = pwdata[ism_pkg::CTL_DIV_LSB +: 7];
            s_next.len = pwdata[ism_pkg::CTL_LEN_LSB +: 8];
            if (pwdata[ism_pkg::CTL_GO])
            begin
              s_next.busy = 1'b1;
              s_next.done = 1'b0;
              s_next.nack = 1'b0;
              s_next.cnt = (pwdata[ism_pkg::CTL_LEN_LSB +: 8] == 8'h00) ?
                           8'h01 : pwdata[ism_pkg::CTL_LEN_LSB +: 8];
              s_next.ph = ism_pkg::PH_ISSUE;
              s_next.st = ism_pkg::ST_EN1;
            end
          end
        ism_pkg::OFS_SLAVE:
          if (!s_reg.busy)
          begin
            s_next.saddr = pwdata[6:0];
          end
        ism_pkg::OFS_TX:
          if (!s_reg.tx_full)
          begin
            s_next.tx_data = pwdata[7:0];
            s_next.tx_full = 1'b1;
          end
        default:
        begin
        end
      endcase
    end
    if (apb_done && !pwrite && (word_addr == ism_pkg::OFS_RX))
    begin
      s_next.rx_valid = 1'b0;
    end

    // peripheral reads: issue, wait one cycle, then evaluate
    if (is_read_state(s_reg.st) && (s_reg.ph != ism_pkg::PH_EVAL))
    begin
      if (s_reg.ph == ism_pkg::PH_ISSUE)
      begin
        s_next.dev.addr = read_addr(s_reg.st);
        s_next.dev.rd = 1'b1;
        s_next.ph = ism_pkg::PH_WAIT;
      end
      else
      begin
        s_next.ph = ism_pkg::PH_EVAL;
      end
    end
    else
    begin
      s_next.ph = ism_pkg::PH_ISSUE;
      case (s_reg.st)
        ism_pkg::ST_IDLE:
        begin
        end
        // both writes set only enable; start follows after the divider write
        ism_pkg::ST_EN1:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_BUS_CONTROL,
                                 cr_pe);
          s_next.st = ism_pkg::ST_EN2;
        end
        ism_pkg::ST_EN2:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_BUS_CONTROL,
                                 cr_pe);
          s_next.st = ism_pkg::ST_SET_CCR;
        end
        ism_pkg::ST_SET_CCR:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_CLOCK_DIVIDER,
                                 {s_reg.fast, s_reg.div});
          s_next.st = ism_pkg::ST_SET_START;
        end
        ism_pkg::ST_SET_START:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_BUS_CONTROL,
                                 cr_pe | cr_start);
          s_next.st = ism_pkg::ST_POLL_SB;
        end
        ism_pkg::ST_POLL_SB:
          if (ev && dev_rdata[ism_pkg::SR1_START_SENT])
          begin
            s_next.st = ism_pkg::ST_WR_ADDR;
          end
        ism_pkg::ST_WR_ADDR:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_DATA,
                                 {s_reg.saddr, s_reg.rx_dir});
          s_next.in_addr = 1'b1;
          s_next.st = ism_pkg::ST_POLL_EV2;
        end
        ism_pkg::ST_POLL_EV2:
          if (ev)
          begin
            s_next.st = ism_pkg::ST_CHK_AF;
          end
        // reading status two also clears the failure flag
        ism_pkg::ST_CHK_AF:
          if (dev_rdata[ism_pkg::SR2_ACK_FAILURE])
          begin
            s_next.st = ism_pkg::ST_FAIL_STOP;
          end
          else if (s_reg.in_addr)
          begin
            s_next.st = ism_pkg::ST_RE_SR1;
          end
          else
          begin
            s_next.st = ism_pkg::ST_TX_POLL;
          end
        ism_pkg::ST_RE_SR1:
          s_next.st = ism_pkg::ST_WR_CR2;
        ism_pkg::ST_WR_CR2:
        begin
          s_next.in_addr = 1'b0;
          s_next.dev = dev_write(ism_pkg::DEV_BUS_CONTROL, cr_pe |
            ((s_reg.rx_dir && (s_reg.cnt != 8'h01)) ?
             cr_ack : 8'h00));
          s_next.st = s_reg.rx_dir ? ism_pkg::ST_RX_POLL : ism_pkg::ST_TX_WR;
        end
        // clock stays held while waiting for software to supply a byte
        ism_pkg::ST_TX_WR:
          if (s_reg.tx_full)
          begin
            s_next.dev = dev_write(ism_pkg::DEV_DATA,
                                   s_reg.tx_data);
            s_next.tx_full = 1'b0;
            s_next.cnt = s_reg.cnt - 8'h01;
            s_next.st = (s_reg.cnt == 8'h01) ? ism_pkg::ST_TX_STOP :
                        ism_pkg::ST_TX_POLL;
          end
        ism_pkg::ST_TX_STOP:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_BUS_CONTROL,
                                 cr_pe | cr_stop);
          s_next.st = ism_pkg::ST_POLL_IDLE;
        end
        ism_pkg::ST_TX_POLL:
          if (ev && dev_rdata[ism_pkg::SR1_BYTE_FINISHED])
          begin
            s_next.st = ism_pkg::ST_TX_WR;
          end
          else if (ev)
          begin
            s_next.st = ism_pkg::ST_CHK_AF;
          end
        // a full receive holder stalls the next byte on the bus
        ism_pkg::ST_RX_POLL:
          if (ev && dev_rdata[ism_pkg::SR1_BYTE_FINISHED] &&
              !s_reg.rx_valid)
          begin
            s_next.st = (s_reg.cnt <= 8'h02) ? ism_pkg::ST_RX_CR :
                        ism_pkg::ST_RX_RD;
          end
        ism_pkg::ST_RX_CR:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_BUS_CONTROL,
            (s_reg.cnt == 8'h01) ? (cr_pe | cr_stop) :
            cr_pe);
          s_next.st = ism_pkg::ST_RX_RD;
        end
        ism_pkg::ST_RX_RD:
        begin
          s_next.rx_data = dev_rdata;
          s_next.rx_valid = 1'b1;
          s_next.cnt = s_reg.cnt - 8'h01;
          s_next.st = (s_reg.cnt == 8'h01) ? ism_pkg::ST_POLL_IDLE :
                      ism_pkg::ST_RX_POLL;
        end
        ism_pkg::ST_POLL_IDLE:
          if (!dev_rdata[ism_pkg::SR1_MASTER_IDLE])
          begin
            s_next.busy = 1'b0;
            s_next.done = 1'b1;
            s_next.st = ism_pkg::ST_IDLE;
          end
        ism_pkg::ST_FAIL_STOP:
        begin
          s_next.dev = dev_write(ism_pkg::DEV_BUS_CONTROL,
                                 cr_pe | cr_stop);
          s_next.nack = 1'b1;
          s_next.in_addr = 1'b0;
          s_next.st = ism_pkg::ST_POLL_IDLE;
        end
        default:
          s_next.st = ism_pkg::ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_reg <= '0;
    end
    else
    begin
      s_reg <= s_next;
    end
  end

  assign prdata = s_reg.prdata;
  assign pready = s_reg.pready;
  assign pslverr = s_reg.pslverr;
  assign dev_req = s_reg.dev;

endmodule // ism_host

// ### ism_pkg.sv
// constants and carriers for the two-wire bus master sequencer
// assumes the peripheral register map sits on an 8-bit parallel port
package ism_pkg;

  // peripheral register addresses
  localparam logic [7:0] DEV_BUS_CONTROL = 8'h5F;
  localparam logic [7:0] DEV_STATUS_ONE = 8'h5E;
  localparam logic [7:0] DEV_STATUS_TWO = 8'h5D;
  localparam logic [7:0] DEV_CLOCK_DIVIDER = 8'h5C;
  localparam logic [7:0] DEV_DATA = 8'h59;

  // bus_control fields
  localparam int CR_PERIPHERAL_ENABLE = 5;
  localparam int CR_START_REQUEST = 3;
  localparam int CR_ACK_ENABLE = 2;
  localparam int CR_STOP_REQUEST = 1;
  localparam int CR_INTERRUPT_ENABLE = 0;

  // status_register_one fields
  localparam int SR1_EVENT = 7;
  localparam int SR1_BYTE_FINISHED = 3;
  localparam int SR1_MASTER_IDLE = 1;
  localparam int SR1_START_SENT = 0;

  // status_register_two fields
  localparam int SR2_ACK_FAILURE = 4;

  // clock_divider_register fields
  localparam int CCR_FAST_SELECT = 7;

  // own register map, byte offsets
  localparam logic [7:0] OFS_CONTROL = 8'h00;
  localparam logic [7:0] OFS_SLAVE = 8'h04;
  localparam logic [7:0] OFS_TX = 8'h08;
  localparam logic [7:0] OFS_RX = 8'h0C;
  localparam logic [7:0] OFS_STATUS = 8'h10;

  // control word fields
  localparam int CTL_GO = 0;
  localparam int CTL_READ = 1;
  localparam int CTL_FAST = 2;
  localparam int CTL_DIV_LSB = 8;
  localparam int CTL_LEN_LSB = 16;

  // status word fields
  localparam int STA_BUSY = 0;
  localparam int STA_DONE = 1;
  localparam int STA_NACK = 2;
  localparam int STA_TX_FULL = 3;
  localparam int STA_RX_VALID = 4;

  // read pipeline phases
  localparam logic [1:0] PH_ISSUE = 2'h0;
  localparam logic [1:0] PH_WAIT = 2'h1;
  localparam logic [1:0] PH_EVAL = 2'h2;

  typedef enum logic [4:0] {
    ST_IDLE = 5'h00,
    ST_EN1 = 5'h01,
    ST_EN2 = 5'h02,
    ST_SET_CCR = 5'h03,
    ST_SET_START = 5'h04,
    ST_POLL_SB = 5'h05,
    ST_WR_ADDR = 5'h06,
    ST_POLL_EV2 = 5'h07,
    ST_CHK_AF = 5'h08,
    ST_RE_SR1 = 5'h09,
    ST_WR_CR2 = 5'h0A,
    ST_TX_WR = 5'h0B,
    ST_TX_STOP = 5'h0C,
    ST_TX_POLL = 5'h0D,
    ST_RX_POLL = 5'h0E,
    ST_RX_CR = 5'h0F,
    ST_RX_RD = 5'h10,
    ST_POLL_IDLE = 5'h11,
    ST_FAIL_STOP = 5'h12
  } ism_state_e;

  // request toward the peripheral register port
  typedef struct packed {
    logic [7:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } ism_dev_s;

  // whole state of the sequencer
  typedef struct packed {
    ism_state_e st;
    logic [1:0] ph;
    logic [7:0] cnt;
    logic in_addr;
    logic rx_dir;
    logic fast;
    logic [6:0] div;
    logic [7:0] len;
    logic [6:0] saddr;
    logic [7:0] tx_data;
    logic tx_full;
    logic [7:0] rx_data;
    logic rx_valid;
    logic busy;
    logic done;
    logic nack;
    ism_dev_s dev;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
  } ism_regs_s;

endpackage

// ### ism_host_assertions.sv
// checker for the host sequencer's apb side and peripheral request port
// assumes it is bound to ism_host and sees only its ports
`timescale 1ns/1ps

module ism_host_assertions (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire ism_pkg::ism_dev_s dev_req,
  input wire logic [7:0] dev_rdata
);
  logic sr1_rd, st_on, ev2_w;
  logic [1:0] pe_n;
  logic [6:0] slv;
  logic [31:0] ctl;
  wire apbw = psel && penable && pready && pwrite;
  wire wcr = dev_req.wr && dev_req.addr == ism_pkg::DEV_BUS_CONTROL;
  wire wdr = dev_req.wr && dev_req.addr == ism_pkg::DEV_DATA;
  wire rdr = dev_req.rd && dev_req.addr == ism_pkg::DEV_DATA;
  wire rs1 = dev_req.rd && dev_req.addr == ism_pkg::DEV_STATUS_ONE;
  wire wcc = dev_req.wr && dev_req.addr == ism_pkg::DEV_CLOCK_DIVIDER;

  // order tracking of peripheral accesses
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {sr1_rd, st_on, ev2_w, pe_n, slv, ctl} <= '0;
    end
    else
    begin
      sr1_rd <= rs1 ? 1'b1 : (wdr || rdr) ? 1'b0 : sr1_rd;
      st_on <= (wcr && dev_req.wdata[3]) ? 1'b1 : wdr ? 1'b0 : st_on;
      ev2_w <= (wdr && st_on) ? 1'b1 : wcr ? 1'b0 : ev2_w;
      if (wcr)
        pe_n <= dev_req.wdata[5] ? pe_n + {1'b0, pe_n != 2'h3} : 2'h0;
      if (apbw && paddr == ism_pkg::OFS_SLAVE)
        slv <= pwdata[6:0];
      if (apbw && paddr == ism_pkg::OFS_CONTROL)
        ctl <= pwdata;
    end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  AST_APB_READY: assert property (psel && !penable
    |=> pready && !$past(pready))
    else $error("pready not given after setup");
  AST_UNMAPPED: assert property (psel && !penable && paddr[7:2] > 6'h04
    |=> pslverr && prdata == 32'h00000000)
    else $error("unmapped access not refused");
  AST_ENABLE_TWICE: assert property (
    wcr && dev_req.wdata[3] |-> pe_n >= 2'h2)
    else $error("start requested before two enable writes");
  AST_CR_RESERVED: assert property (
    wcr |-> dev_req.wdata[7:6] == 2'h0 && !dev_req.wdata[4] &&
    dev_req.wdata[5])
    else $error("control write with reserved bit or enable low");
  AST_ADDR_BYTE: assert property (
    wdr && st_on |-> dev_req.wdata == {slv, ctl[1]})
    else $error("address byte differs from slave and direction");
  AST_SR1_BEFORE_DR: assert property (wdr |-> sr1_rd)
    else $error("data write without status one read");
  AST_SR1_BEFORE_CR: assert property (wcr && ev2_w |-> sr1_rd)
    else $error("control write after address without status read");
  AST_SR1_BEFORE_RD: assert property (rdr |-> sr1_rd)
    else $error("data read without status one read");
  AST_DIVIDER: assert property (
    wcc |-> dev_req.wdata == {ctl[2], ctl[14:8]})
    else $error("clock divider write differs from control word");
  AST_POLL_START: assert property (
    wcr && dev_req.wdata[3] |=> ##[0:3] rs1)
    else $error("no status poll after start request");
endmodule // ism_host_assertions

// ### ism_dev_model.sv
// behavioural model of the two-wire master peripheral's register port
// assumes one request per cycle; serial byte time folded into dly cycles
`timescale 1ns/1ps

module ism_dev_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire ism_pkg::ism_dev_s dev_req,
  output logic [7:0] dev_rdata,
  input wire logic nak,
  input wire logic [7:0] dly,
  output logic [31:0] tx_log,
  output logic [7:0] ack_log,
  output logic seq_err
);
  logic [7:0] cr, sr1, sr2, dr, clock_divider_register, cnt, rxn;
  logic [2:0] act;
  logic arm, rx, adr;
  wire [7:0] wd = dev_req.wdata;

  always @(posedge pclk or negedge presetn)
    if (!presetn)
    begin
      {cr, sr1, sr2, dr, clock_divider_register, cnt, rxn, act, arm, rx, adr} <= '0;
      {tx_log, ack_log, seq_err, dev_rdata} <= '0;
    end
    else
    begin
      // idle read port shows no stale value
      dev_rdata <= ~dev_rdata;
      if (cnt != 8'h00)
        cnt <= cnt - 8'h01;
      if (cnt == 8'h01)
        case (act)
          3'h1:
          begin
            sr1 <= sr1 | 8'h81;
            cr[3] <= 1'b0;
          end
          3'h2:
          begin
            sr1[7] <= 1'b1;
            sr2[4] <= nak;
          end
          3'h3:
          begin
            sr1 <= sr1 | (rx ? 8'h88 : 8'hA8);
            if (rx)
            begin
              dr <= 8'hA0 + rxn;
              rxn <= rxn + 8'h01;
              ack_log <= {ack_log[6:0], cr[2]};
            end
          end
          default:
          begin
            sr1 <= 8'h00;
            cr[1] <= 1'b0;
          end
        endcase
      if (dev_req.rd)
        case (dev_req.addr)
          ism_pkg::DEV_STATUS_ONE:
          begin
            dev_rdata <= sr1;
            arm <= 1'b1;
          end
          ism_pkg::DEV_STATUS_TWO:
          begin
            dev_rdata <= sr2;
            sr2 <= 8'h00;
            if (sr2[4])
              sr1[7] <= 1'b0;
          end
          ism_pkg::DEV_DATA:
          begin
            dev_rdata <= dr;
            seq_err <= seq_err | ~arm;
            arm <= 1'b0;
            sr1 <= sr1 & 8'h56;
            act <= cr[1] ? 3'h4 : 3'h3;
            cnt <= dly;
          end
          ism_pkg::DEV_BUS_CONTROL:
            dev_rdata <= cr;
          ism_pkg::DEV_CLOCK_DIVIDER:
            dev_rdata <= clock_divider_register;
          default:
            dev_rdata <= 8'h00;
        endcase
      if (dev_req.wr)
        case (dev_req.addr)
          ism_pkg::DEV_BUS_CONTROL:
            if (!wd[5])
            begin
              cr <= wd & 8'h02;
              {sr1, sr2} <= '0;
            end
            else if (!cr[5])
              cr <= 8'h20;
            else
            begin
              cr <= wd & 8'h2F;
              if (wd[3])
              begin
                sr1[1] <= 1'b1;
                act <= 3'h1;
                cnt <= dly;
              end
              else if (adr || (wd[1] && !rx))
              begin
                seq_err <= seq_err | (adr & ~arm);
                sr1[7] <= 1'b0;
                adr <= 1'b0;
                act <= wd[1] ? 3'h4 : 3'h3;
                cnt <= (wd[1] || rx) ? dly : 8'h00;
              end
            end
          ism_pkg::DEV_CLOCK_DIVIDER:
            clock_divider_register <= wd;
          ism_pkg::DEV_DATA:
          begin
            tx_log <= {tx_log[23:0], wd};
            seq_err <= seq_err | ~arm;
            arm <= 1'b0;
            sr1 <= sr1 & 8'h56;
            act <= sr1[0] ? 3'h2 : 3'h3;
            adr <= sr1[0];
            rx <= sr1[0] ? wd[0] : rx;
            cnt <= dly;
          end
          default:
            dr <= dr;
        endcase
    end
endmodule // ism_dev_model

// ### testbench.sv
// self-checking bench: host sequencer against the peripheral model
// assumes package, design, model and checker are compiled first
`timescale 1ns/1ps

module testbench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic nak = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [7:0] dly = 8'h01;
  logic [31:0] pwdata = 32'h00000000;
  logic [31:0] prdata, rd, tx_log;
  logic pready, pslverr, perr, seq_err;
  logic [7:0] dev_rdata, ack_log;
  ism_pkg::ism_dev_s dev_req;
  int error_cnt = 0;
  int total_checks = 0;

  always #2.5 pclk = ~pclk;

  ism_host ism_host_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .dev_req(dev_req), .dev_rdata(dev_rdata));
  ism_dev_model ism_dev_model_i (.pclk(pclk), .presetn(presetn),
    .dev_req(dev_req), .dev_rdata(dev_rdata), .nak(nak), .dly(dly),
    .tx_log(tx_log), .ack_log(ack_log), .seq_err(seq_err));

  task end_sim;
    $display("checks %0d mismatches %0d", total_checks, error_cnt);
    if (error_cnt == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      error_cnt++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (n = 0; n < 9; n++)
    begin
      @(posedge pclk);
      if (pready === 1'b1)
        break;
    end
    rd = prdata;
    perr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (n == 9)
    begin
      error_cnt++;
      end_sim;
    end
  endtask

  task poll(input int b, input logic v);
    int n;
    for (n = 0; n < 400; n++)
    begin
      apb(1'b0, ism_pkg::OFS_STATUS, 32'h00000000);
      if (rd[b] === v)
        break;
    end
    if (n == 400)
    begin
      error_cnt++;
      end_sim;
    end
  endtask

  task t_regs;
    apb(1'b0, ism_pkg::OFS_STATUS, 32'h00000000);
    chk(rd, 32'h00000000);
    apb(1'b0, 8'h20, 32'h00000000);
    chk({31'h00000000, perr}, 32'h00000001);
    chk(rd, 32'h00000000);
    $display("test regs done");
  endtask

  task t_write;
    dly <= 8'h28;
    apb(1'b1, ism_pkg::OFS_SLAVE, 32'h00000055);
    apb(1'b1, ism_pkg::OFS_TX, 32'h0000003C);
    apb(1'b1, ism_pkg::OFS_CONTROL, 32'h00020305);
    poll(ism_pkg::STA_TX_FULL, 1'b0);
    apb(1'b1, ism_pkg::OFS_TX, 32'h000000C3);
    poll(ism_pkg::STA_BUSY, 1'b0);
    chk({30'h00000000, rd[2:1]}, 32'h00000001);
    chk({8'h00, tx_log[23:0]}, 32'h00AA3CC3);
    chk({31'h00000000, seq_err}, 32'h00000000);
    $display("test write done");
  endtask

  task t_read;
    int i;
    dly <= 8'h01;
    apb(1'b1, ism_pkg::OFS_SLAVE, 32'h00000021);
    apb(1'b1, ism_pkg::OFS_CONTROL, 32'h00030703);
    for (i = 0; i < 3; i++)
    begin
      poll(ism_pkg::STA_RX_VALID, 1'b1);
      apb(1'b0, ism_pkg::OFS_RX, 32'h00000000);
      chk({24'h000000, rd[7:0]}, {24'h000000, 8'hA0 + i[7:0]});
    end
    poll(ism_pkg::STA_BUSY, 1'b0);
    chk({30'h00000000, rd[2:1]}, 32'h00000001);
    chk({29'h00000000, ack_log[2:0]}, 32'h00000006);
    chk({24'h000000, tx_log[7:0]}, 32'h00000043);
    chk({31'h00000000, seq_err}, 32'h00000000);
    apb(1'b0, ism_pkg::OFS_CONTROL, 32'h00000000);
    chk(rd, 32'h00030702);
    $display("test read done");
  endtask

  task t_nack;
    nak <= 1'b1;
    dly <= 8'h05;
    apb(1'b1, ism_pkg::OFS_SLAVE, 32'h00000010);
    apb(1'b1, ism_pkg::OFS_CONTROL, 32'h00010101);
    poll(ism_pkg::STA_BUSY, 1'b0);
    chk({31'h00000000, rd[2]}, 32'h00000001);
    chk({24'h000000, tx_log[7:0]}, 32'h00000020);
    nak <= 1'b0;
    $display("test nack done");
  endtask

  initial
  begin
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    t_regs;
    t_write;
    t_read;
    t_nack;
    end_sim;
  end
endmodule // testbench

bind ism_host ism_host_assertions ism_host_assertions_i (.pclk(pclk),
  .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
  .pslverr(pslverr), .dev_req(dev_req), .dev_rdata(dev_rdata));
